// ==== verilog/azs_pkg.sv ====
/*
  Constants for the offset auto-zero sequencer: I/O port addresses,
  port codes, approximation start values and strobe timing.
  Assumes a 250 MHz system clock.
*/
package azs_pkg;

  // ------------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;

  // ------------------------------------------------------------------
  // I/O port addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV = 8'he4;
  localparam logic [7:0] ADDR_TRIM = 8'he5;
  localparam logic [7:0] ADDR_SWITCH = 8'he6;
  localparam logic [7:0] ADDR_CTRL = 8'he7;

  // ------------------------------------------------------------------
  // Port codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_WORD_MODE0 = 8'h90;
  localparam logic [7:0] SWITCH_ZEROING = 8'h01;
  localparam logic [7:0] SWITCH_TOGGLE = 8'h03;
  localparam logic [7:0] POINTER_INIT = 8'h80;
  localparam logic [7:0] TRIM_INIT = 8'h7f;
  localparam logic [7:0] DATA_INVERT = 8'hff;
  localparam logic [15:0] READ_ROUTINE_ADDR = 16'h3c3d;

  // ------------------------------------------------------------------
  // Strobe timing
  // ------------------------------------------------------------------
  localparam int WR_STROBE_NS = 20;
  localparam int RD_ACCESS_NS = 135;
  localparam int WR_STROBE_CYC_I = (WR_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_ACCESS_CYC_I = (RD_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [5:0] WR_STROBE_CYC = 6'(WR_STROBE_CYC_I);
  localparam logic [5:0] RD_ACCESS_CYC = 6'(RD_ACCESS_CYC_I);

  // ------------------------------------------------------------------
  // Sequencer states, Gray along the zeroing path except the AZS_EVAL to AZS_LOAD and AZS_NORMAL to AZS_IDLE steps
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    AZS_IDLE = 4'h0,
    AZS_CFG = 4'h1,
    AZS_SHORT = 4'h3,
    AZS_LOAD = 4'h2,
    AZS_START = 4'h6,
    AZS_WAIT = 4'h7,
    AZS_READ = 4'h5,
    AZS_EVAL = 4'h4,
    AZS_DONE = 4'hc,
    AZS_NORMAL = 4'hd,
    AZS_MSTART = 4'hf,
    AZS_MWAIT = 4'he,
    AZS_MREAD = 4'ha
  } azs_state_e;

endpackage

// ==== verilog/azs_sequencer.sv ====
/*
  Offset auto-zero sequencer: drives the parallel port interface of a
  switched preamp and 8-bit converter, finds the trim word by successive
  approximation, then runs normal conversions on request.
  Assumes inverting buffers on the converter data lines only, an active-low
  conversion-done interrupt pin and static converter data while read.
*/
`timescale 1ns/1ps
module azs_sequencer #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cal_start,
  input wire logic meas_start,
  input wire logic conversion_done_interrupt_n,
  input wire logic [DATA_W-1:0] io_rdata,
  output logic [7:0] io_addr,
  output logic [DATA_W-1:0] io_wdata,
  output logic io_wr,
  output logic io_rd,
  output logic busy,
  output logic zeroed,
  output logic [DATA_W-1:0] result,
  output logic result_valid,
  output logic [DATA_W-1:0] trim_code,
  output logic [15:0] branch_addr
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic int_s1;
  logic int_s2;
  logic int_s3;
  logic int_level;
  logic int_fall;
  logic [DATA_W-1:0] rd_s1;
  logic [DATA_W-1:0] rd_s2;
  logic [DATA_W-1:0] rd_s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_s1 <= 1'b1;
      int_s2 <= 1'b1;
      int_s3 <= 1'b1;
      rd_s1 <= '0;
      rd_s2 <= '0;
      rd_s3 <= '0;
    end else if (ce) begin
      int_s1 <= conversion_done_interrupt_n;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
      rd_s1 <= io_rdata;
      rd_s2 <= rd_s1;
      rd_s3 <= rd_s2;
    end
  end

  // Accepted interrupt level changes once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_level <= 1'b1;
    end else if (ce && (int_s2 == int_s3)) begin
      int_level <= int_s3;
    end
  end

  assign int_fall = int_level && !int_s2 && !int_s3;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  azs_pkg::azs_state_e state;
  logic [5:0] cnt;
  logic [DATA_W-1:0] pointer;
  logic [DATA_W-1:0] conv_data;
  logic [DATA_W-1:0] next_trim;
  logic [DATA_W-1:0] next_pointer;
  logic wr_done;
  logic rd_ready;

  assign wr_done = (cnt == azs_pkg::WR_STROBE_CYC);
  assign rd_ready = (cnt >= azs_pkg::RD_ACCESS_CYC) && (rd_s2 == rd_s3);

  // Trial evaluation per the approximation step
  always_comb begin
    next_trim = trim_code;
    if (conv_data != '0) begin
      next_trim = trim_code | pointer;
    end
    next_pointer = pointer >> 1;
    next_trim = next_trim ^ next_pointer;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= azs_pkg::AZS_IDLE;
      cnt <= '0;
      io_addr <= '0;
      io_wdata <= '0;
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      busy <= 1'b0;
      zeroed <= 1'b0;
      pointer <= '0;
      trim_code <= '0;
      conv_data <= '0;
      result <= '0;
      result_valid <= 1'b0;
      branch_addr <= '0;
    end else if (ce) begin
      result_valid <= 1'b0;
      case (state)
        azs_pkg::AZS_IDLE: begin
          if (cal_start) begin
            busy <= 1'b1;
            zeroed <= 1'b0;
            cnt <= '0;
            state <= azs_pkg::AZS_CFG;
          end else if (meas_start && zeroed) begin
            busy <= 1'b1;
            cnt <= '0;
            state <= azs_pkg::AZS_MSTART;
          end
        end
        azs_pkg::AZS_CFG: begin
          io_addr <= azs_pkg::ADDR_CTRL;
          io_wdata <= azs_pkg::CTRL_WORD_MODE0;
          io_wr <= !wr_done;
          cnt <= wr_done ? 6'h00 : cnt + 6'h01;
          if (wr_done) begin
            state <= azs_pkg::AZS_SHORT;
          end
        end
        azs_pkg::AZS_SHORT: begin
          io_addr <= azs_pkg::ADDR_SWITCH;
          io_wdata <= azs_pkg::SWITCH_ZEROING;
          io_wr <= !wr_done;
          cnt <= wr_done ? 6'h00 : cnt + 6'h01;
          if (wr_done) begin
            pointer <= azs_pkg::POINTER_INIT;
            trim_code <= azs_pkg::TRIM_INIT;
            state <= azs_pkg::AZS_LOAD;
          end
        end
        azs_pkg::AZS_LOAD: begin
          io_addr <= azs_pkg::ADDR_TRIM;
          io_wdata <= trim_code;
          io_wr <= !wr_done;
          cnt <= wr_done ? 6'h00 : cnt + 6'h01;
          if (wr_done) begin
            state <= azs_pkg::AZS_START;
          end
        end
        azs_pkg::AZS_START, azs_pkg::AZS_MSTART: begin
          io_addr <= azs_pkg::ADDR_CONV;
          io_wdata <= '0;
          io_wr <= !wr_done;
          cnt <= wr_done ? 6'h00 : cnt + 6'h01;
          if (wr_done) begin
            state <= (state == azs_pkg::AZS_START) ? azs_pkg::AZS_WAIT : azs_pkg::AZS_MWAIT;
          end
        end
        azs_pkg::AZS_WAIT, azs_pkg::AZS_MWAIT: begin
          if (int_fall) begin
            branch_addr <= azs_pkg::READ_ROUTINE_ADDR;
            cnt <= '0;
            state <= (state == azs_pkg::AZS_WAIT) ? azs_pkg::AZS_READ : azs_pkg::AZS_MREAD;
          end
        end
        azs_pkg::AZS_READ, azs_pkg::AZS_MREAD: begin
          io_addr <= azs_pkg::ADDR_CONV;
          io_rd <= !rd_ready;
          if (!rd_ready) begin
            cnt <= cnt + 6'h01;
          end else begin
            cnt <= '0;
            if (state == azs_pkg::AZS_READ) begin
              conv_data <= rd_s3 ^ azs_pkg::DATA_INVERT;
              state <= azs_pkg::AZS_EVAL;
            end else begin
              result <= rd_s3 ^ azs_pkg::DATA_INVERT;
              result_valid <= 1'b1;
              busy <= 1'b0;
              state <= azs_pkg::AZS_IDLE;
            end
          end
        end
        azs_pkg::AZS_EVAL: begin
          // Pointer walks 80 down to 01: eight trials
          if (next_pointer == '0) begin
            if (conv_data != '0) begin
              trim_code <= trim_code | pointer;
            end
            state <= azs_pkg::AZS_DONE;
          end else begin
            trim_code <= next_trim;
            pointer <= next_pointer;
            state <= azs_pkg::AZS_LOAD;
          end
        end
        azs_pkg::AZS_DONE: begin
          io_addr <= azs_pkg::ADDR_SWITCH;
          io_wdata <= azs_pkg::SWITCH_ZEROING ^ azs_pkg::SWITCH_TOGGLE;
          io_wr <= !wr_done;
          cnt <= wr_done ? 6'h00 : cnt + 6'h01;
          if (wr_done) begin
            state <= azs_pkg::AZS_NORMAL;
          end
        end
        azs_pkg::AZS_NORMAL: begin
          // Last trim write stays on the port
          zeroed <= 1'b1;
          busy <= 1'b0;
          state <= azs_pkg::AZS_IDLE;
        end
        default: begin
          io_wr <= 1'b0;
          io_rd <= 1'b0;
          busy <= 1'b0;
          state <= azs_pkg::AZS_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== tb/azs_dev.sv ====
/* Converter, switched preamp and parallel port seen from the sequencer.
   Port writes land when the strobe falls; shares the bench clock and reset. */
`timescale 1ns/1ps
module azs_dev (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] offset,
  input wire logic [7:0] sig,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic irq_n,
  output logic [7:0] io_rdata,
  output logic [7:0] ctrl_port,
  output logic [7:0] switch_port,
  output logic [7:0] first_trim
);
  logic wr_d;
  logic arm;
  logic [7:0] conv;
  logic [7:0] trim;
  logic [7:0] pat;
  int cnt;
  // Inverted data pins; released bus toggles
  assign io_rdata = (io_rd && io_addr == 8'he4) ? ~conv : pat;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_d, arm, irq_n} <= 3'b001;
      {conv, trim, ctrl_port, switch_port, first_trim} <= 40'h0;
      cnt <= 0;
      pat <= 8'h5a;
    end else begin
      wr_d <= io_wr;
      pat <= ~pat;
      if (io_rd && io_addr == 8'he4) begin
        irq_n <= 1'b1;
      end
      if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        irq_n <= 1'b0;
        conv <= (switch_port != 8'h01) ? sig : (trim < offset) ? offset - trim : 8'h00;
      end
      if (wr_d && !io_wr) begin
        case (io_addr)
          8'he7: ctrl_port <= io_wdata;
          8'he6: begin
            switch_port <= io_wdata;
            arm <= 1'b1;
          end
          8'he5: begin
            trim <= io_wdata;
            arm <= 1'b0;
            if (arm) first_trim <= io_wdata;
          end
          8'he4: begin
            cnt <= slow ? 60 : 10;
            irq_n <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ==== tb/azs_sva.sv ====
/* Port checker for the sequencer.
   Bound to azs_sequencer; one clock domain. */
`timescale 1ns/1ps
module azs_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cal_start,
  input wire logic conversion_done_interrupt_n,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic busy,
  input wire logic zeroed,
  input wire logic [15:0] branch_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] rd_cnt;
  logic [3:0] n_conv;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt <= 8'h00;
      n_conv <= 4'h0;
    end else if (ce) begin
      rd_cnt <= io_rd ? rd_cnt + 8'h01 : 8'h00;
      if (cal_start && !busy) begin
        n_conv <= 4'h0;
      end else if ($rose(io_wr) && io_addr == 8'he4) begin
        n_conv <= n_conv + 4'h1;
      end
    end
  end
  sequence s_cfg;
    io_wr && io_addr == 8'he7 && io_wdata == 8'h90;
  endsequence
  sequence s_strobe;
    io_wr [*5] ##1 !io_wr;
  endsequence
  a_cfg_first: assert property (
    cal_start && ce && !busy |=> busy ##[0:3] s_cfg) else $error("no control word");
  a_wr_width: assert property (
    $rose(io_wr) |-> s_strobe) else $error("write strobe width");
  a_wr_hold: assert property (
    io_wr && $past(io_wr) |-> $stable({io_addr, io_wdata})) else $error("write unstable");
  a_read_port: assert property (
    io_rd |-> io_addr == 8'he4 && !io_wr) else $error("read address");
  a_read_irq: assert property (
    $rose(io_rd) |-> !conversion_done_interrupt_n && branch_addr == 16'h3c3d)
    else $error("read without interrupt");
  a_read_width: assert property (
    $fell(io_rd) |-> rd_cnt >= 8'h22) else $error("read too short");
  a_eight_trials: assert property (
    $rose(zeroed) |-> n_conv == 4'h8 && io_addr == 8'he6 && io_wdata == 8'h02)
    else $error("trial count or switch code");
  a_short_code: assert property (
    io_wr && io_addr == 8'he6 && n_conv == 4'h0 |-> io_wdata == 8'h01)
    else $error("short switch not closed before trials");
  a_trim_frozen: assert property (
    zeroed |-> !(io_wr && io_addr == 8'he5)) else $error("trim moved after zeroing");
endmodule
bind azs_sequencer azs_sva i_azs_sva (.clk(clk), .rst_n(rst_n), .ce(ce),
  .cal_start(cal_start), .conversion_done_interrupt_n(conversion_done_interrupt_n),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .busy(busy),
  .zeroed(zeroed), .branch_addr(branch_addr));

// ==== tb/azs_sequencer_bench.sv ====
/* Self-checking bench for azs_sequencer.
   Uses azs_dev as converter, preamp and parallel port. */
`timescale 1ns/1ps
module azs_sequencer_bench;
  logic clk;
  logic rst_n = 1'b0, ce = 1'b1, cal = 1'b0, meas = 1'b0, slow = 1'b0;
  logic irq_n, wr, rd, busy, zeroed, rv;
  logic [7:0] rdata, addr, wdata, result, trim, ctrl_p, sw_p, first_p;
  logic [7:0] offset = 8'h00, sig = 8'h00;
  logic [15:0] branch;
  logic [7:0] rows [4][2] = '{'{8'h00, 8'h00}, '{8'hff, 8'hff}, '{8'h80, 8'ha5}, '{8'h3c, 8'h5a}};
  int n_mismatch = 0, cmp_count = 0;
  azs_sequencer i_azs_sequencer (.clk(clk), .rst_n(rst_n), .ce(ce), .cal_start(cal),
    .meas_start(meas), .conversion_done_interrupt_n(irq_n), .io_rdata(rdata), .io_addr(addr),
    .io_wdata(wdata), .io_wr(wr), .io_rd(rd), .busy(busy), .zeroed(zeroed), .result(result),
    .result_valid(rv), .trim_code(trim), .branch_addr(branch));
  azs_dev i_azs_dev (.clk(clk), .rst_n(rst_n), .slow(slow), .offset(offset), .sig(sig),
    .io_addr(addr), .io_wdata(wdata), .io_wr(wr), .io_rd(rd), .irq_n(irq_n), .io_rdata(rdata),
    .ctrl_port(ctrl_p), .switch_port(sw_p), .first_trim(first_p));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_on(input logic want_rv, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (want_rv ? rv === 1'b1 : busy === 1'b0) return;
    end
    n_mismatch++;
    close_out();
  endtask
  task pulse(input logic c);
    @(posedge clk);
    cal <= c;
    meas <= !c;
    @(posedge clk);
    cal <= 1'b0;
    meas <= 1'b0;
  endtask
  function automatic logic [7:0] approximation_register(input logic [7:0] k);
    logic [7:0] c = 8'h7f;
    for (logic [7:0] b = 8'h80; b != 8'h00; b = b >> 1) begin
      if (c < k) c = c | b;
      if (b > 8'h01) c = c ^ (b >> 1);
    end
    return c;
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({busy, zeroed, wr, rd, rv, branch[10:0]}, 16'h0000);
    pulse(1'b0);
    @(negedge clk);
    check(busy, 16'h0000);
    @(posedge clk);
    ce <= 1'b0;
    pulse(1'b1);
    ce <= 1'b1;
    @(negedge clk);
    check(busy, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      offset <= rows[i][0];
      sig <= rows[i][1];
      slow <= i[0];
      pulse(1'b1);
      wait_on(1'b0, 3000);
      check(trim, approximation_register(rows[i][0]));
      check({zeroed, first_p}, {1'b1, 8'h7f});
      check(sw_p, 8'h01 ^ 8'h03);
      check(ctrl_p, 8'h90);
      pulse(1'b0);
      wait_on(1'b1, 1000);
      check(result, rows[i][1]);
      wait_on(1'b0, 20);
    end
    offset <= 8'h3c;
    pulse(1'b1);
    pulse(1'b1);
    pulse(1'b0);
    wait_on(1'b0, 3000);
    check(trim, approximation_register(8'h3c));
    pulse(1'b1);
    repeat (150) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({busy, zeroed, wr, rd, trim}, 16'h0000);
    close_out();
  end
endmodule
